// [ssd_pkg.sv]
// Package for the serial status, data buffer and bit-rate block
// Function
// - Transmitter-empty sets on buffer-to-shifter; reset sets
// - Empty flag requests CPU or DMA per enable
// - Status read then data write clears empty
// - First transmitter enable sets empty flag
// - Complete flag set when empty and idle
// - Complete clears on queueing or DMA write
// - Receiver-full sets on shifter-to-buffer, requests service
// - Status read then data read clears full
// - Idle sets after idle line, interrupt gated by its enable and by receive DMA off
// - Idle armed only after a received character
// - Overrun sets on unread buffer, drops character
// - Overrun cleared only if status saw it
// - Noise flag sets, interrupts, read-sequence cleared
// - Framing flag sets on zero stop bit
// - Parity flag sets on parity check failure
// - Break sets break, framing, full; clears ninth in nine-bit mode
// - Status-two read then data read clears break
// - Reception-active follows start search, no interrupt
// - One bit-rate register, prescale bits reset zero
// - Rate is clock over 64 times divisors
package ssd_pkg;
  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h10;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h14;
  localparam logic [7:0] ADDR_DATA_BUF = 8'h18;
  localparam logic [7:0] ADDR_BIT_RATE = 8'h1c;
  localparam logic [7:0] ADDR_CONTROL = 8'h20;
  // ------------------------------------------------------------
  // Status one bit positions
  // ------------------------------------------------------------
  localparam int S1_TX_EMPTY = 7;
  localparam int S1_TX_DONE = 6;
  localparam int S1_RX_FULL = 5;
  localparam int S1_IDLE = 4;
  localparam int S1_OVERRUN = 3;
  localparam int S1_NOISE = 2;
  localparam int S1_FRAMING = 1;
  localparam int S1_PARITY = 0;
  // ------------------------------------------------------------
  // Status two bit positions
  // ------------------------------------------------------------
  localparam int S2_BREAK = 1;
  localparam int S2_RX_ACTIVE = 0;
  // ------------------------------------------------------------
  // Control register bit positions
  // ------------------------------------------------------------
  localparam int C_TX_EMPTY_IE = 0;
  localparam int C_DONE_IE = 1;
  localparam int C_RX_FULL_IE = 2;
  localparam int C_IDLE_IE = 3;
  localparam int C_OVERRUN_IE = 4;
  localparam int C_NOISE_IE = 5;
  localparam int C_FRAMING_IE = 6;
  localparam int C_PARITY_IE = 7;
  localparam int C_TX_DMA = 8;
  localparam int C_RX_DMA = 9;
  localparam int C_TX_EN = 10;
  localparam int C_RX_EN = 11;
  localparam int C_NINE_BIT = 12;
  localparam int CTRL_W = 13;
  // ------------------------------------------------------------
  // Reset values and rate constants
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_ONE_RST = 8'hc0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [7:0] BIT_RATE_RST = 8'h00;
  localparam logic [15:0] RATE_BASE_DIV = 16'h0040;
  localparam int BR_PRE_LSB = 4;
  localparam int BR_SEL_LSB = 0;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Prescale code to divisor 1/3/4/13
  function automatic logic [3:0] ssd_prescale(input logic [1:0] code);
    unique case (code)
      2'h0: ssd_prescale = 4'h1;
      2'h1: ssd_prescale = 4'h3;
      2'h2: ssd_prescale = 4'h4;
      default: ssd_prescale = 4'hd;
    endcase
  endfunction : ssd_prescale
endpackage : ssd_pkg

// [ssd_core.sv]
// Serial status flags, data buffer and bit-rate divider with APB slave
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module ssd_core
  import ssd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic dma_wr_i,
  input wire logic [7:0] dma_wdata_i,
  input wire logic dma_rd_i,
  input wire logic tx_load_i,
  output logic [7:0] tx_data_o,
  input wire logic tx_busy_i,
  input wire logic tx_queued_i,
  input wire logic rx_done_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_ninth_i,
  input wire logic rx_noise_i,
  input wire logic rx_stop_zero_i,
  input wire logic rx_parity_bad_i,
  input wire logic rx_break_i,
  input wire logic rx_idle_line_i,
  input wire logic rx_line_ones_i,
  input wire logic start_slot_zero_i,
  input wire logic false_start_i,
  output logic received_ninth_bit_o,
  output logic bit_rate_tick_o,
  output logic tx_irq_o,
  output logic tx_dma_req_o,
  output logic rx_irq_o,
  output logic rx_dma_req_o,
  output logic err_irq_o
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] status_one_reg;
  logic brk_reg, rx_active_reg, idle_armed_reg, brk_rearm_reg, tx_en_seen_reg;
  logic [7:0] snap_one_reg;
  logic snap_brk_reg;
  logic [7:0] rx_buf_reg;
  logic [7:0] tx_buf_reg;
  logic ninth_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [7:0] bit_rate_reg;
  logic [31:0] prdata_reg;
  logic [23:0] div_cnt_reg;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire acc = psel_i & penable_i & clk_en_i;
  wire wr = acc & pwrite_i;
  wire rd = acc & ~pwrite_i;
  wire hit_s1 = paddr_i == ADDR_STATUS_ONE;
  wire hit_s2 = paddr_i == ADDR_STATUS_TWO;
  wire hit_db = paddr_i == ADDR_DATA_BUF;
  wire hit_br = paddr_i == ADDR_BIT_RATE;
  wire hit_ct = paddr_i == ADDR_CONTROL;
  wire mapped = hit_s1 | hit_s2 | hit_db | hit_br | hit_ct;
  wire rd_s1 = rd & hit_s1;
  wire rd_s2 = rd & hit_s2;
  wire cpu_db_wr = wr & hit_db;
  wire cpu_db_rd = rd & hit_db;
  wire ce_dma_wr = dma_wr_i & clk_en_i;
  wire ce_dma_rd = dma_rd_i & clk_en_i;
  wire tx_dma = ctrl_reg[C_TX_DMA];
  wire rx_dma = ctrl_reg[C_RX_DMA];

  // ------------------------------------------------------------
  // Flag clear terms
  // ------------------------------------------------------------
  // Only flags captured by the status read are cleared, so late events survive
  wire [7:0] clr_one_rd = cpu_db_rd ? (snap_one_reg & 8'h3f) : 8'h00;
  wire clr_empty = (cpu_db_wr & snap_one_reg[S1_TX_EMPTY]) | ce_dma_wr;
  wire clr_brk = cpu_db_rd & snap_brk_reg;
  wire first_tx_en = wr & hit_ct & pwdata_i[C_TX_EN] & ~tx_en_seen_reg;

  wire overrun_evt = rx_done_i & status_one_reg[S1_RX_FULL] & ~clr_one_rd[S1_RX_FULL] & ~ce_dma_rd;
  wire accept_rx = (rx_done_i & ~overrun_evt) | rx_break_i;

  // ------------------------------------------------------------
  // Next state of status one, set wins over clear
  // ------------------------------------------------------------
  logic [7:0] s1_set;
  logic [7:0] s1_clr;
  always_comb begin
    s1_set = 8'h00;
    s1_set[S1_TX_EMPTY] = tx_load_i | first_tx_en;
    // Empty about to clear must not keep complete alive, else a DMA write could never clear it
    s1_set[S1_TX_DONE] = status_one_reg[S1_TX_EMPTY] & ~clr_empty & ~tx_busy_i & ~tx_queued_i;
    s1_set[S1_RX_FULL] = accept_rx | rx_break_i;
    s1_set[S1_IDLE] = rx_idle_line_i & idle_armed_reg;
    s1_set[S1_OVERRUN] = overrun_evt;
    s1_set[S1_NOISE] = rx_noise_i;
    s1_set[S1_FRAMING] = rx_stop_zero_i | rx_break_i;
    s1_set[S1_PARITY] = rx_parity_bad_i;
    s1_clr = clr_one_rd;
    s1_clr[S1_TX_EMPTY] = clr_empty;
    s1_clr[S1_TX_DONE] = tx_queued_i | ce_dma_wr;
    s1_clr[S1_RX_FULL] = clr_one_rd[S1_RX_FULL] | ce_dma_rd;
  end
  wire [7:0] status_one_next = s1_set | (status_one_reg & ~s1_clr);

  wire brk_set = rx_break_i & brk_rearm_reg;
  wire [7:0] status_two = {6'h00, brk_reg, rx_active_reg};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_one_reg <= STATUS_ONE_RST;
      brk_reg <= 1'b0;
      rx_active_reg <= 1'b0;
      idle_armed_reg <= 1'b0;
      brk_rearm_reg <= 1'b1;
      tx_en_seen_reg <= 1'b0;
      snap_one_reg <= 8'h00;
      snap_brk_reg <= 1'b0;
    end else if (clk_en_i) begin
      status_one_reg <= status_one_next;
      brk_reg <= brk_set | (brk_reg & ~clr_brk);
      if (brk_set) begin
        brk_rearm_reg <= 1'b0;
      end else if (rx_line_ones_i) begin
        brk_rearm_reg <= 1'b1;
      end
      if (start_slot_zero_i) begin
        rx_active_reg <= 1'b1;
      end else if (false_start_i | rx_idle_line_i | rx_done_i) begin
        rx_active_reg <= 1'b0;
      end
      // Re-armed by a valid character, disarmed on receiver enable, on idle setting and on idle clearing
      if (accept_rx & ~rx_break_i) begin
        idle_armed_reg <= 1'b1;
      end else if ((wr & hit_ct & pwdata_i[C_RX_EN] & ~ctrl_reg[C_RX_EN]) | clr_one_rd[S1_IDLE] | s1_set[S1_IDLE]) begin
        idle_armed_reg <= 1'b0;
      end
      if (first_tx_en) begin
        tx_en_seen_reg <= 1'b1;
      end
      // Snapshot the word the bus returned, so a flag set after the setup cycle survives
      if (rd_s1) begin
        snap_one_reg <= prdata_reg[7:0];
      end else if (cpu_db_rd | cpu_db_wr) begin
        snap_one_reg <= 8'h00;
      end
      if (rd_s2) begin
        snap_brk_reg <= prdata_reg[S2_BREAK];
      end else if (cpu_db_rd) begin
        snap_brk_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Data buffer, no reset so contents survive it
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (clk_en_i) begin
      if (accept_rx) begin
        rx_buf_reg <= rx_break_i ? 8'h00 : rx_data_i;
        ninth_reg <= (rx_break_i & ctrl_reg[C_NINE_BIT]) ? 1'b0 : rx_ninth_i;
      end
      if (cpu_db_wr) begin
        tx_buf_reg <= pwdata_i[7:0];
      end else if (ce_dma_wr) begin
        tx_buf_reg <= dma_wdata_i;
      end
    end
  end

  // ------------------------------------------------------------
  // Control and bit-rate registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
      bit_rate_reg <= BIT_RATE_RST;
    end else if (wr) begin
      if (hit_ct) begin
        ctrl_reg <= pwdata_i[CTRL_W-1:0];
      end
      if (hit_br) begin
        bit_rate_reg <= {1'b0, pwdata_i[6:4], 1'b0, pwdata_i[2:0]} & 8'h37;
      end
    end
  end

  // ------------------------------------------------------------
  // Bit-rate divider: one tick per bit time
  // ------------------------------------------------------------
  // Largest divisor 64 * 13 * 128 needs 17 bits; the shift is done at 24 bits
  wire [3:0] pre_div = ssd_prescale(bit_rate_reg[BR_PRE_LSB +: 2]);
  wire [2:0] sel = bit_rate_reg[BR_SEL_LSB +: 3];
  wire [16:0] base_pre = 17'(RATE_BASE_DIV * pre_div);
  wire [23:0] full_div = 24'(base_pre) << sel;
  wire [23:0] div_last = full_div - 24'h000001;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= 24'h000000;
      bit_rate_tick_o <= 1'b0;
    end else if (clk_en_i) begin
      bit_rate_tick_o <= (div_cnt_reg == div_last);
      div_cnt_reg <= (div_cnt_reg >= div_last) ? 24'h000000 : div_cnt_reg + 24'h000001;
    end
  end

  // ------------------------------------------------------------
  // Read data and slave answer
  // ------------------------------------------------------------
  wire [31:0] rd_mux = hit_s1 ? {24'h0, status_one_reg} :
                       hit_s2 ? {24'h0, status_two} :
                       hit_db ? {24'h0, rx_buf_reg} :
                       hit_br ? {24'h0, bit_rate_reg} :
                       hit_ct ? {19'h0, ctrl_reg} : UNMAPPED_DATA;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata_o = prdata_reg;
  assign pready_o = clk_en_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign tx_data_o = tx_buf_reg;
  assign received_ninth_bit_o = ninth_reg;

  // ------------------------------------------------------------
  // Request routing
  // ------------------------------------------------------------
  wire empty_req = status_one_reg[S1_TX_EMPTY] & ctrl_reg[C_TX_EMPTY_IE];
  assign tx_irq_o = (empty_req & ~tx_dma) | (status_one_reg[S1_TX_DONE] & ctrl_reg[C_DONE_IE]);
  assign tx_dma_req_o = empty_req & tx_dma;
  wire full_req = status_one_reg[S1_RX_FULL] & ctrl_reg[C_RX_FULL_IE];
  assign rx_irq_o = (full_req | (status_one_reg[S1_IDLE] & ctrl_reg[C_IDLE_IE])) & ~rx_dma;
  assign rx_dma_req_o = full_req & rx_dma;
  assign err_irq_o = (status_one_reg[S1_OVERRUN] & ctrl_reg[C_OVERRUN_IE]) |
                     (status_one_reg[S1_NOISE] & ctrl_reg[C_NOISE_IE]) |
                     (status_one_reg[S1_FRAMING] & ctrl_reg[C_FRAMING_IE]) |
                     (status_one_reg[S1_PARITY] & ctrl_reg[C_PARITY_IE]);
endmodule : ssd_core

// [ssd_monitor.sv]
// Checker for the serial status block: service requests, errors, bit-rate tick
`timescale 1ns/1ps
module ssd_monitor
  import ssd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pslverr_o,
  input wire logic dma_wr_i,
  input wire logic tx_load_i,
  input wire logic rx_done_i,
  input wire logic rx_stop_zero_i,
  input wire logic rx_break_i,
  input wire logic bit_rate_tick_o,
  input wire logic tx_irq_o,
  input wire logic tx_dma_req_o,
  input wire logic rx_irq_o,
  input wire logic rx_dma_req_o,
  input wire logic err_irq_o
);
  // ----------------------------------------
  // Shadow of the control register
  // ----------------------------------------
  logic [CTRL_W-1:0] ctl_reg;
  wire logic acc = psel_i & penable_i & clk_en_i;
  // Events in a write cycle are skipped: the enables may change under them
  wire logic calm = clk_en_i & !(acc & pwrite_i);
  wire logic mapped = paddr_i inside {ADDR_STATUS_ONE, ADDR_STATUS_TWO, ADDR_DATA_BUF, ADDR_BIT_RATE, ADDR_CONTROL};
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ctl_reg <= CTRL_RST;
    else if (acc & pwrite_i & (paddr_i == ADDR_CONTROL))
      ctl_reg <= pwdata_i[CTRL_W-1:0];
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_unmapped; acc |-> pslverr_o == !mapped; endproperty
  a_unmapped: assert property (p_unmapped) else $error("slave error wrong");
  property p_tx_excl; !(tx_irq_o & tx_dma_req_o); endproperty
  a_tx_excl: assert property (p_tx_excl) else $error("tx irq and dma both");
  property p_tx_set; tx_load_i & calm & ctl_reg[C_TX_EMPTY_IE] & !ctl_reg[C_TX_DMA] |=> tx_irq_o; endproperty
  a_tx_set: assert property (p_tx_set) else $error("no tx irq after load");
  property p_dma_clr; dma_wr_i & calm & !tx_load_i & ctl_reg[C_TX_DMA] |=> !tx_dma_req_o; endproperty
  a_dma_clr: assert property (p_dma_clr) else $error("tx dma request kept");
  property p_rx_req;
    rx_done_i & calm & ctl_reg[C_RX_FULL_IE] |=> (ctl_reg[C_RX_DMA] ? rx_dma_req_o & !rx_irq_o : rx_irq_o);
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx request wrong");
  property p_frame; (rx_stop_zero_i | rx_break_i) & calm & ctl_reg[C_FRAMING_IE] |=> err_irq_o; endproperty
  a_frame: assert property (p_frame) else $error("no framing irq");
  // A frozen tick is held, so only a tick seen under enable must drop
  property p_tick; bit_rate_tick_o & clk_en_i |=> !bit_rate_tick_o [*8]; endproperty
  a_tick: assert property (p_tick) else $error("bit tick too close");
  property p_rx_excl; !(rx_irq_o & rx_dma_req_o); endproperty
  a_rx_excl: assert property (p_rx_excl) else $error("rx irq and dma both");
endmodule : ssd_monitor

bind ssd_core ssd_monitor u_mon (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pslverr_o(pslverr_o), .dma_wr_i(dma_wr_i), .tx_load_i(tx_load_i), .rx_done_i(rx_done_i),
  .rx_stop_zero_i(rx_stop_zero_i), .rx_break_i(rx_break_i), .bit_rate_tick_o(bit_rate_tick_o),
  .tx_irq_o(tx_irq_o), .tx_dma_req_o(tx_dma_req_o), .rx_irq_o(rx_irq_o), .rx_dma_req_o(rx_dma_req_o),
  .err_irq_o(err_irq_o));

// [ssd_far_model.sv]
// Far serial peer, reduced to receive events and transmit-shifter handshakes
`timescale 1ns/1ps
module ssd_far_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_load_o,
  output logic tx_busy_o,
  output logic tx_queued_o,
  output logic rx_done_o,
  output logic rx_ninth_o,
  output logic rx_noise_o,
  output logic rx_stop_zero_o,
  output logic rx_parity_bad_o,
  output logic rx_break_o,
  output logic rx_idle_line_o,
  output logic rx_line_ones_o,
  output logic start_slot_zero_o,
  output logic false_start_o,
  output logic [7:0] rx_data_o
);
  logic [7:0] shift_reg;
  initial begin
    {tx_load_o, tx_busy_o, tx_queued_o, rx_done_o, rx_ninth_o, rx_noise_o, rx_stop_zero_o} = '0;
    {rx_parity_bad_o, rx_break_o, rx_idle_line_o, start_slot_zero_o, false_start_o} = '0;
    rx_line_ones_o = 1'b1;
    rx_data_o = 8'h5a;
  end
  // One-cycle burst, m = {false, start, idle, break, parity, stop, noise, done}
  task automatic ev(input logic [7:0] m, input logic [7:0] d, input logic nine);
    {false_start_o, start_slot_zero_o, rx_idle_line_o, rx_break_o} <= m[7:4];
    {rx_parity_bad_o, rx_stop_zero_o, rx_noise_o, rx_done_o} <= m[3:0];
    rx_data_o <= d;
    rx_ninth_o <= nine;
    rx_line_ones_o <= !m[4];
    @(posedge clk_sys_i);
    {false_start_o, start_slot_zero_o, rx_idle_line_o, rx_break_o, rx_parity_bad_o} <= '0;
    {rx_stop_zero_o, rx_noise_o, rx_done_o} <= '0;
    // Stale data is inverted so it never passes for a fresh character
    rx_data_o <= ~d;
    rx_ninth_o <= ~nine;
    rx_line_ones_o <= 1'b1;
    @(posedge clk_sys_i);
  endtask : ev
  task automatic tx_go();
    {tx_load_o, tx_queued_o, tx_busy_o} <= 3'b111;
    @(posedge clk_sys_i);
    shift_reg <= tx_data_i;
    {tx_load_o, tx_queued_o} <= 2'b00;
    @(posedge clk_sys_i);
  endtask : tx_go
  task automatic tx_end();
    tx_busy_o <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask : tx_end
endmodule : ssd_far_model

// [tb.sv]
// Self-checking bench for the serial status, data buffer and bit-rate block
`timescale 1ns/1ps
module tb;
  import ssd_pkg::*;
  logic clk_sys_i, rst_n_i, clk_en_i, psel, penable, pwrite, dma_wr, dma_rd, pready, pslverr, nine, e;
  logic tick, tx_irq, tx_dma, rx_irq, rx_dma, err_irq, txl, txb, txq, rdn, r9, rn, rs, rp, rb, ri, ro, ss, fs;
  logic [7:0] paddr, dma_wd, tx_data, rx_d;
  logic [31:0] pwdata, prdata, q, v;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 25;
  int n;
  ssd_core u_ssd_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .dma_wr_i(dma_wr), .dma_wdata_i(dma_wd), .dma_rd_i(dma_rd),
    .tx_load_i(txl), .tx_data_o(tx_data), .tx_busy_i(txb), .tx_queued_i(txq), .rx_done_i(rdn),
    .rx_data_i(rx_d), .rx_ninth_i(r9), .rx_noise_i(rn), .rx_stop_zero_i(rs), .rx_parity_bad_i(rp),
    .rx_break_i(rb), .rx_idle_line_i(ri), .rx_line_ones_i(ro), .start_slot_zero_i(ss), .false_start_i(fs),
    .received_ninth_bit_o(nine), .bit_rate_tick_o(tick), .tx_irq_o(tx_irq), .tx_dma_req_o(tx_dma),
    .rx_irq_o(rx_irq), .rx_dma_req_o(rx_dma), .err_irq_o(err_irq));
  ssd_far_model u_ssd_far_model (.clk_sys_i(clk_sys_i), .tx_data_i(tx_data), .tx_load_o(txl), .tx_busy_o(txb),
    .tx_queued_o(txq), .rx_done_o(rdn), .rx_ninth_o(r9), .rx_noise_o(rn), .rx_stop_zero_o(rs),
    .rx_parity_bad_o(rp), .rx_break_o(rb), .rx_idle_line_o(ri), .rx_line_ones_o(ro),
    .start_slot_zero_o(ss), .false_start_o(fs), .rx_data_o(rx_d));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------
  // Checking, bus and expectation helpers
  // ----------------------------------------
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd
  task automatic dma(input logic w);
    dma_wr <= w;
    dma_rd <= !w;
    @(posedge clk_sys_i);
    {dma_wr, dma_rd} <= 2'b00;
    @(posedge clk_sys_i);
  endtask : dma
  function automatic int period(input int p, input int s);
    int pd[4] = '{1, 3, 4, 13};
    return 64 * pd[p] * (1 << s);
  endfunction : period
  initial begin
    {clk_en_i, psel, penable, pwrite, dma_wr, dma_rd, rst_n_i} = 7'b1000000;
    {paddr, dma_wd, pwdata} = '0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(ADDR_STATUS_ONE, 32'hc0);
    rd(ADDR_STATUS_TWO, 32'h0);
    apb(1'b1, ADDR_STATUS_ONE, 32'hff);
    rd(ADDR_STATUS_ONE, 32'hc0);
    rd(8'h08, 32'h0);
    chk({31'h0, e}, 32'h1);
    rd(ADDR_BIT_RATE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'b1, ADDR_BIT_RATE, v);
      rd(ADDR_BIT_RATE, v & 32'h37);
      apb(1'b1, ADDR_BIT_RATE, 32'(i << 4 | i & 1));
      repeat (2) do @(posedge clk_sys_i); while (tick !== 1'b1);
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n++;
      end while (tick !== 1'b1);
      chk(n, period(i, i & 1));
    end
    apb(1'b1, ADDR_CONTROL, 32'h18fc);
    u_ssd_far_model.ev(8'h20, 8'h00, 1'b0);
    rd(ADDR_STATUS_ONE, 32'hc0);
    v = $random(seed);
    u_ssd_far_model.ev(8'h01, v[7:0], 1'b1);
    chk({rx_irq, nine}, 32'h3);
    u_ssd_far_model.ev(8'h20, 8'h00, 1'b0);
    rd(ADDR_STATUS_ONE, 32'hf0);
    rd(ADDR_DATA_BUF, v & 32'hff);
    rd(ADDR_STATUS_ONE, 32'hc0);
    u_ssd_far_model.ev(8'h20, 8'h00, 1'b0);
    rd(ADDR_STATUS_ONE, 32'hc0);
    u_ssd_far_model.ev(8'h01, v[7:0], 1'b0);
    rd(ADDR_STATUS_ONE, 32'he0);
    u_ssd_far_model.ev(8'h01, ~v[7:0], 1'b0);
    chk(err_irq, 1'b1);
    rd(ADDR_DATA_BUF, v & 32'hff);
    rd(ADDR_STATUS_ONE, 32'hc8);
    rd(ADDR_DATA_BUF, v & 32'hff);
    rd(ADDR_STATUS_ONE, 32'hc0);
    for (int k = 1; k < 4; k++) begin
      u_ssd_far_model.ev(8'(1 << k | 1), v[7:0], 1'b1);
      chk(err_irq, 1'b1);
      rd(ADDR_STATUS_ONE, 32'he0 | 32'(8 >> k));
      rd(ADDR_DATA_BUF, v & 32'hff);
      rd(ADDR_STATUS_ONE, 32'hc0);
    end
    u_ssd_far_model.ev(8'h10, 8'h00, 1'b0);
    chk(nine, 1'b0);
    rd(ADDR_STATUS_ONE, 32'he2);
    rd(ADDR_STATUS_TWO, 32'h2);
    rd(ADDR_DATA_BUF, 32'h0);
    rd(ADDR_STATUS_TWO, 32'h0);
    u_ssd_far_model.ev(8'h40, 8'h00, 1'b0);
    rd(ADDR_STATUS_TWO, 32'h1);
    u_ssd_far_model.ev(8'h80, 8'h00, 1'b0);
    rd(ADDR_STATUS_TWO, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h0401);
    chk(tx_irq, 1'b1);
    rd(ADDR_STATUS_ONE, 32'hc0);
    apb(1'b1, ADDR_DATA_BUF, v);
    chk({tx_irq, tx_data}, {23'h0, 1'b0, v[7:0]});
    u_ssd_far_model.tx_go();
    chk(tx_irq, 1'b1);
    rd(ADDR_STATUS_ONE, 32'h80);
    chk(u_ssd_far_model.shift_reg, v[7:0]);
    u_ssd_far_model.tx_end();
    rd(ADDR_STATUS_ONE, 32'hc0);
    apb(1'b1, ADDR_CONTROL, 32'h0501);
    chk({tx_dma, tx_irq}, 32'h2);
    dma_wd <= ~v[7:0];
    dma(1'b1);
    chk(tx_dma, 1'b0);
    chk(tx_data, {24'h0, ~v[7:0]});
    rd(ADDR_STATUS_ONE, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h0a04);
    u_ssd_far_model.ev(8'h01, v[7:0], 1'b0);
    chk({rx_dma, rx_irq}, 32'h2);
    dma(1'b0);
    chk(rx_dma, 1'b0);
    // A low clock enable must hold every flag and the bus answer
    clk_en_i <= 1'b0;
    u_ssd_far_model.ev(8'h01, v[7:0], 1'b0);
    chk(pready, 1'b0);
    clk_en_i <= 1'b1;
    rd(ADDR_STATUS_ONE, 32'h0);
    close_out();
  end
endmodule : tb
